/* verilog/cws_store.sv */
// configuration word store: primary, extended and identity words
// assumes the programmer presents one command per cycle on the port
`timescale 1ns/100ps
module cws_store #(
   parameter logic [3:0] ID_RAM_MEM = 4'hb
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_prog_mode,
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [1:0] i_cmd,
   input wire logic [11:0] i_addr,
   input wire logic [11:0] i_wdata,
   output logic o_ack,
   output logic o_hit,
   output logic [11:0] o_rdata,
   output logic [11:0] o_primary_word,
   output logic [11:0] o_extended_word,
   output logic [11:0] o_identity_word,
   output logic o_osc_div4,
   output logic o_sync_inputs,
   output logic o_option_six_bits,
   output logic [7:0] o_option_force_mask,
   output logic o_deep_stack,
   output logic o_internal_osc,
   output logic [2:0] o_rc_rate,
   output logic [12:0] o_rc_khz,
   output logic o_code_lock,
   output logic o_watchdog_on,
   output logic [1:0] o_osc_kind,
   output logic o_carry_in_used,
   output logic o_brownout_on,
   output logic [3:0] o_ram_banks,
   output logic [2:0] o_prog_pages,
   output logic [3:0] o_prog_banks
);
   initial
   begin
      if (ID_RAM_MEM > 4'hf)
      begin
         $error("identity code out of range");
      end
   end
   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   cws_wr_if prim_if ();
   cws_wr_if ext_if ();
   cws_word_reg #(.RST_VAL(cws_pkg::PRIMARY_RST)) u_prim (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .port(prim_if.dst)
   );
   cws_word_reg #(.RST_VAL(cws_pkg::EXT_RST)) u_ext (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .port(ext_if.dst)
   );
   // identity value is arbitrary; low nibble is ram and size code
   // hard-wired identity
   localparam logic [11:0] ID_WORD = {cws_pkg::ID_RES_BITS, ID_RAM_MEM};
   // ------------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------------
   logic go;
   logic sel_prim;
   logic sel_ext;
   logic sel_id;
   assign go = i_req && i_prog_mode;
   assign sel_prim = go && (i_cmd == cws_pkg::CMD_MEM) && (i_addr == cws_pkg::PRIMARY_ADDR);
   assign sel_ext = go && (i_cmd == cws_pkg::CMD_EXT);
   assign sel_id = go && (i_cmd == cws_pkg::CMD_ID);
   assign prim_if.we = sel_prim && i_wr;
   assign prim_if.data = i_wdata;
   // preset bits of the extended word are not guarded; the programmer keeps them
   assign ext_if.we = sel_ext && i_wr;
   assign ext_if.data = i_wdata;
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic ack;
      logic hit;
      logic [11:0] rdata;
      logic [11:0] pw;
      logic [11:0] xw;
      logic [11:0] id;
      logic deep;
      logic irc_on;
      logic lock;
      logic carry;
      logic bor_on;
      logic [3:0] banks;
      logic [2:0] pages;
      logic [3:0] pbanks;
      logic [12:0] khz;
   } cws_st_s;
   cws_st_s st_r;
   cws_st_s st_nxt;
   logic [11:0] pw;
   logic [11:0] xw;
   assign pw = prim_if.q;
   assign xw = ext_if.q;
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.ack = go;
      st_nxt.hit = sel_prim || sel_ext || sel_id;
      st_nxt.pw = pw;
      st_nxt.xw = xw;
      st_nxt.id = ID_WORD;
      // active-low selects of the primary word and the extended carry select; brown-out is on unless its field is BOR_OFF
      st_nxt.deep = !pw[cws_pkg::P_DEEP_STACK_SELECT];
      st_nxt.irc_on = !pw[cws_pkg::P_IRC];
      st_nxt.lock = !pw[cws_pkg::P_LOCK];
      st_nxt.carry = !xw[cws_pkg::X_CARRY];
      st_nxt.bor_on = xw[cws_pkg::X_BOR_HI:cws_pkg::X_BOR_LO] != cws_pkg::BOR_OFF;
      // a primary or extended write echoes its data in the ack cycle for read-back checking
      if (sel_prim)
      begin
         st_nxt.rdata = i_wr ? i_wdata : pw;
      end
      else if (sel_ext)
      begin
         st_nxt.rdata = i_wr ? i_wdata : xw;
      end
      else if (sel_id)
      begin
         st_nxt.rdata = ID_WORD;
      end
      else
      begin
         st_nxt.rdata = 12'h0000;
      end
      st_nxt.banks = 4'h1 << xw[cws_pkg::X_RAM_HI:cws_pkg::X_RAM_LO];
      case (xw[cws_pkg::X_MEM_HI:cws_pkg::X_MEM_LO])
         2'h0:
         begin
            st_nxt.pages = 3'h1;
            st_nxt.pbanks = 4'h1;
         end
         2'h1:
         begin
            st_nxt.pages = 3'h1;
            st_nxt.pbanks = 4'h2;
         end
         2'h2:
         begin
            st_nxt.pages = 3'h4;
            st_nxt.pbanks = 4'h4;
         end
         default:
         begin
            st_nxt.pages = 3'h4;
            st_nxt.pbanks = 4'h8;
         end
      endcase
      st_nxt.khz = 13'(cws_pkg::RC_BASE_KHZ) >> pw[cws_pkg::P_RATE_HI:cws_pkg::P_RATE_LO];
   end
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         st_r <= '{ack: 1'b0, hit: 1'b0, rdata: 12'h0000, pw: cws_pkg::PRIMARY_RST,
                   xw: cws_pkg::EXT_RST, id: ID_WORD, deep: 1'b0, irc_on: 1'b0,
                   lock: 1'b0, carry: 1'b0, bor_on: 1'b0, banks: 4'h8, pages: 3'h4,
                   pbanks: 4'h8, khz: 13'h001f};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   // ------------------------------------------------------------------
   // outputs, all from flip-flops
   // ------------------------------------------------------------------
   assign o_ack = st_r.ack;
   assign o_hit = st_r.hit;
   assign o_rdata = st_r.rdata;
   assign o_primary_word = st_r.pw;
   assign o_extended_word = st_r.xw;
   assign o_identity_word = st_r.id;
   assign o_osc_div4 = st_r.pw[cws_pkg::P_FAST];
   assign o_sync_inputs = st_r.pw[cws_pkg::P_SYNC];
   assign o_option_six_bits = st_r.pw[cws_pkg::P_OPTX];
   assign o_option_force_mask = {{2{st_r.pw[cws_pkg::P_OPTX]}}, 6'h00};
   assign o_deep_stack = st_r.deep;
   assign o_internal_osc = st_r.irc_on;
   assign o_rc_rate = st_r.pw[cws_pkg::P_RATE_HI:cws_pkg::P_RATE_LO];
   assign o_rc_khz = st_r.khz;
   assign o_code_lock = st_r.lock;
   assign o_watchdog_on = st_r.pw[cws_pkg::P_WDT];
   assign o_osc_kind = st_r.pw[cws_pkg::P_OSC_HI:cws_pkg::P_OSC_LO];
   assign o_carry_in_used = st_r.carry;
   assign o_brownout_on = st_r.bor_on;
   assign o_ram_banks = st_r.banks;
   assign o_prog_pages = st_r.pages;
   assign o_prog_banks = st_r.pbanks;
endmodule : cws_store

/* verilog/cws_pkg.sv */
// package for the configuration word store: map, field positions, codes
// assumes a 12-bit programming port and 200 MHz system clock
package cws_pkg;
   // ------------------------------------------------------------------
   // widths and map
   // ------------------------------------------------------------------
   localparam int WORD_W = 12;
   localparam int ADDR_W = 12;
   localparam logic [11:0] PRIMARY_ADDR = 12'h0fff;
   // ------------------------------------------------------------------
   // programming commands
   // ------------------------------------------------------------------
   localparam logic [1:0] CMD_MEM = 2'h0;
   localparam logic [1:0] CMD_EXT = 2'h1;
   localparam logic [1:0] CMD_ID = 2'h2;
   localparam logic [1:0] CMD_NONE = 2'h3;
   // ------------------------------------------------------------------
   // primary word fields
   // ------------------------------------------------------------------
   localparam int P_FAST = 11;
   localparam int P_SYNC = 10;
   localparam int P_OPTX = 9;
   localparam int P_DEEP_STACK_SELECT = 8;
   localparam int P_IRC = 7;
   localparam int P_RATE_HI = 6;
   localparam int P_RATE_LO = 4;
   localparam int P_LOCK = 3;
   localparam int P_WDT = 2;
   localparam int P_OSC_HI = 1;
   localparam int P_OSC_LO = 0;
   // ------------------------------------------------------------------
   // extended word fields
   // ------------------------------------------------------------------
   localparam int X_PRESET_HI = 11;
   localparam int X_PRESET_LO = 7;
   localparam int X_CARRY = 6;
   localparam int X_BOR_HI = 5;
   localparam int X_BOR_LO = 4;
   localparam int X_RAM_HI = 3;
   localparam int X_RAM_LO = 2;
   localparam int X_MEM_HI = 1;
   localparam int X_MEM_LO = 0;
   localparam logic [1:0] BOR_OFF = 2'h3;
   // ------------------------------------------------------------------
   // reset values (erased state)
   // ------------------------------------------------------------------
   localparam logic [11:0] PRIMARY_RST = 12'h0fff;
   localparam logic [11:0] EXT_RST = 12'h0fff;
   localparam logic [7:0] ID_RES_BITS = 8'hff;
   // ------------------------------------------------------------------
   // internal rc
   // ------------------------------------------------------------------
   localparam int RC_BASE_KHZ = 4000;
   localparam int RC_KHZ_W = 13;
endpackage : cws_pkg

/* verilog/cws_wr_if.sv */
// interface carrying one word-write strobe between store modules
// assumes a single system clock domain
`timescale 1ns/100ps
interface cws_wr_if;
   logic we;
   logic [11:0] data;
   logic [11:0] q;
   modport src (output we, output data, input q);
   modport dst (input we, input data, output q);
endinterface : cws_wr_if

/* verilog/cws_word_reg.sv */
// one 12-bit storage word with reset value and write strobe
// assumes synchronous active-low reset
`timescale 1ns/100ps
module cws_word_reg #(
   parameter logic [11:0] RST_VAL = 12'h0fff
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   cws_wr_if.dst port
);
   typedef struct packed {
      logic [11:0] word;
   } cws_wst_s;
   cws_wst_s st_r;
   cws_wst_s st_nxt;
   always_comb
   begin
      st_nxt = st_r;
      if (port.we)
      begin
         st_nxt.word = port.data;
      end
   end
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         st_r <= '{word: RST_VAL};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign port.q = st_r.word;
endmodule : cws_word_reg

/* testbench/cws_store_props.sv */
// checker for the configuration word store ports
// assumes one clock domain and sync active-low reset
`timescale 1ns/100ps
module cws_store_props #(
   parameter logic [3:0] ID_RAM_MEM = 4'hb
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_prog_mode,
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [1:0] i_cmd,
   input wire logic [11:0] i_addr,
   input wire logic [11:0] i_wdata,
   input wire logic o_ack,
   input wire logic o_hit,
   input wire logic [11:0] o_rdata,
   input wire logic [11:0] o_primary_word,
   input wire logic [11:0] o_extended_word,
   input wire logic [11:0] o_identity_word,
   input wire logic o_carry_in_used,
   input wire logic o_brownout_on
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_taken; i_req && i_prog_mode; endsequence
   sequence s_locked; !i_prog_mode [*3]; endsequence
   sequence s_ext_wr; s_taken ##0 (i_wr && i_cmd == cws_pkg::CMD_EXT); endsequence
   sequence s_miss; s_taken ##0 (i_cmd == cws_pkg::CMD_MEM && i_addr != 12'h0fff); endsequence
   sequence s_id_acc; s_taken ##0 (i_cmd == cws_pkg::CMD_ID); endsequence
   a_ack_follows: assert property (s_taken |=> o_ack)
      else $error("ack missing after a request");
   a_no_stray_ack: assert property (!(i_req && i_prog_mode) |=> !o_ack)
      else $error("ack without a request");
   a_words_locked: assert property (s_locked |-> !$past(i_rst_n) || !$past(i_rst_n, 2) ||
      ($stable(o_primary_word) && $stable(o_extended_word)))
      else $error("word changed outside programming mode");
   a_id_fixed: assert property (s_id_acc |=> o_hit &&
      o_rdata == {cws_pkg::ID_RES_BITS, ID_RAM_MEM} &&
      o_identity_word == {cws_pkg::ID_RES_BITS, ID_RAM_MEM})
      else $error("identity word changed");
   a_mem_miss: assert property (s_miss |=> !o_hit && o_rdata == 12'h0000)
      else $error("miss address hit");
   a_ext_store: assert property (s_ext_wr |-> ##2 o_extended_word == $past(i_wdata, 2))
      else $error("extended word not stored");
   a_carry_low: assert property (o_carry_in_used == !o_extended_word[cws_pkg::X_CARRY])
      else $error("carry select polarity wrong");
   a_bor_off: assert property (o_brownout_on ==
      (o_extended_word[cws_pkg::X_BOR_HI:cws_pkg::X_BOR_LO] != cws_pkg::BOR_OFF))
      else $error("brown-out decode wrong");
endmodule : cws_store_props
bind cws_store cws_store_props #(.ID_RAM_MEM(ID_RAM_MEM)) u_props (
   .i_sys_clk(i_sys_clk),
   .i_rst_n(i_rst_n),
   .i_prog_mode(i_prog_mode),
   .i_req(i_req),
   .i_wr(i_wr),
   .i_cmd(i_cmd),
   .i_addr(i_addr),
   .i_wdata(i_wdata),
   .o_ack(o_ack),
   .o_hit(o_hit),
   .o_rdata(o_rdata),
   .o_primary_word(o_primary_word),
   .o_extended_word(o_extended_word),
   .o_identity_word(o_identity_word),
   .o_carry_in_used(o_carry_in_used),
   .o_brownout_on(o_brownout_on)
);

/* testbench/cws_prog_model.sv */
// programmer model driving the store's programming port
// assumes inputs change at the falling clock edge
`timescale 1ns/100ps
module cws_prog_model (
   input wire logic i_sys_clk,
   input wire logic i_ack,
   input wire logic i_hit,
   input wire logic [11:0] i_rdata,
   output logic o_prog_mode,
   output logic o_req,
   output logic o_wr,
   output logic [1:0] o_cmd,
   output logic [11:0] o_addr,
   output logic [11:0] o_wdata
);
   logic ack_seen, hit_seen;
   logic [11:0] rdata_seen;
   initial
   begin
      o_prog_mode = 1'b0;
      o_req = 1'b0;
      o_wr = 1'b0;
      o_cmd = cws_pkg::CMD_NONE;
      o_addr = 12'h0000;
      o_wdata = 12'h0000;
   end
   // one access, then one cycle for the word outputs to settle
   task access(input logic [1:0] cmd, input logic [11:0] a, input logic wr, input logic [11:0] d);
   begin
      @(negedge i_sys_clk);
      o_req = 1'b1;
      o_wr = wr;
      o_cmd = cmd;
      o_addr = a;
      o_wdata = d;
      @(negedge i_sys_clk);
      {ack_seen, hit_seen, rdata_seen} = {i_ack, i_hit, i_rdata};
      o_req = 1'b0;
      o_cmd = cws_pkg::CMD_NONE;
      o_addr = ~a;
      o_wdata = ~d;
      @(negedge i_sys_clk);
   end
   endtask : access
   // programming mode changes only at a falling edge
   task set_mode(input logic m);
   begin
      @(negedge i_sys_clk);
      o_prog_mode = m;
   end
   endtask : set_mode
   task ext_write(input logic [6:0] low);
   begin
      access(cws_pkg::CMD_EXT, 12'h0000, 1'b0, 12'h0000);
      access(cws_pkg::CMD_EXT, 12'h0000, 1'b1, {rdata_seen[11:7], low});
   end
   endtask : ext_write
endmodule : cws_prog_model

/* testbench/tb.sv */
// testbench: programming-port tests of the configuration word store
// assumes the programmer model cws_prog_model
`timescale 1ns/100ps
module tb;
   localparam logic [3:0] ID_NIB = 4'h6; // arbitrary value
   logic i_sys_clk, i_rst_n, i_prog_mode, i_req, i_wr;
   logic [1:0] i_cmd, o_osc_kind, c;
   logic [11:0] i_addr, i_wdata, o_rdata, o_primary_word, o_extended_word, o_identity_word;
   logic o_ack, o_hit, o_osc_div4, o_sync_inputs, o_option_six_bits, o_deep_stack;
   logic o_internal_osc, o_code_lock, o_watchdog_on, o_carry_in_used, o_brownout_on;
   logic [7:0] o_option_force_mask;
   logic [2:0] o_rc_rate, o_prog_pages, r;
   logic [12:0] o_rc_khz;
   logic [3:0] o_ram_banks, o_prog_banks;
   int err_count = 0;
   int n_checks = 0;
   int pg[4] = '{1, 1, 4, 4};
   int bk[4] = '{1, 2, 4, 8};
   cws_store #(.ID_RAM_MEM(ID_NIB)) uut (.*);
   cws_prog_model prog (.i_sys_clk(i_sys_clk), .i_ack(o_ack), .i_hit(o_hit), .i_rdata(o_rdata),
      .o_prog_mode(i_prog_mode), .o_req(i_req), .o_wr(i_wr), .o_cmd(i_cmd), .o_addr(i_addr),
      .o_wdata(i_wdata));
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
   begin
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask : chk
   task print_verdict;
   begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask : print_verdict
   initial
   begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   initial
   begin
      #50000;
      err_count++;
      print_verdict();
   end
   initial
   begin
      i_rst_n = 1'b0;
      repeat (6) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      chk("primary", o_primary_word, cws_pkg::PRIMARY_RST);
      chk("extended", o_extended_word, cws_pkg::EXT_RST);
      chk("identity", o_identity_word, {cws_pkg::ID_RES_BITS, ID_NIB});
      $display("test reset done");
      prog.access(cws_pkg::CMD_MEM, 12'h0fff, 1'b1, 12'h0123);
      chk("ack off", prog.ack_seen, 0);
      chk("primary off", o_primary_word, 12'h0fff);
      prog.set_mode(1'b1);
      prog.access(cws_pkg::CMD_MEM, 12'h0fff, 1'b1, 12'h05a3);
      chk("echo", {prog.ack_seen, prog.hit_seen, prog.rdata_seen}, 14'h35a3);
      chk("primary", o_primary_word, 12'h05a3);
      prog.access(cws_pkg::CMD_MEM, 12'h0ffe, 1'b1, 12'h0000);
      chk("miss", {prog.ack_seen, prog.hit_seen, prog.rdata_seen}, 14'h2000);
      prog.access(cws_pkg::CMD_MEM, 12'h0fff, 1'b0, 12'h0000);
      chk("read", prog.rdata_seen, 12'h05a3);
      prog.access(cws_pkg::CMD_ID, 12'h0000, 1'b1, 12'h0000);
      chk("id wr", {prog.hit_seen, prog.rdata_seen}, {1'b1, cws_pkg::ID_RES_BITS, ID_NIB});
      chk("id word", o_identity_word, {cws_pkg::ID_RES_BITS, ID_NIB});
      $display("test access done");
      for (int i = 0; i < 8; i++)
      begin
         r = i[2:0];
         prog.access(cws_pkg::CMD_MEM, 12'h0fff, 1'b1,
            {r[0], r[2], r[1], r[2], r[1], r, r[0], r[1], r[2], r[0]});
         chk("khz", o_rc_khz, 16'(4000 >> i));
         chk("div4", o_osc_div4, r[0]);
         chk("six", {o_option_six_bits, o_option_force_mask}, {r[1], r[1], r[1], 6'h00});
         chk("sync", o_sync_inputs, r[2]);
         chk("irc", {o_internal_osc, o_osc_kind}, {!r[1], r[2], r[0]});
         chk("rate", {o_deep_stack, o_rc_rate}, {!r[2], r});
         chk("lock", {o_code_lock, o_watchdog_on}, {!r[0], r[1]});
      end
      $display("test primary fields done");
      for (int i = 0; i < 4; i++)
      begin
         c = i[1:0];
         prog.ext_write({1'b0, c, c, c});
         chk("ext", o_extended_word, {5'h1f, 1'b0, c, c, c});
         chk("carry", o_carry_in_used, 1);
         chk("bor", o_brownout_on, c != 2'b11);
         chk("ram", o_ram_banks, 16'(1 << i));
         chk("size", {o_prog_pages, o_prog_banks}, 16'(pg[i] * 16 + bk[i]));
      end
      prog.ext_write(7'h40);
      chk("carry off", o_carry_in_used, 0);
      prog.set_mode(1'b0);
      prog.access(cws_pkg::CMD_EXT, 12'h0000, 1'b1, 12'h0000);
      chk("ext off", {prog.ack_seen, o_extended_word}, 13'h0fc0);
      $display("test extended fields done");
      print_verdict();
   end
endmodule : tb
